// ---- hdl/sram_host_ctrl.sv ----
// Synchronous host controller driving the asynchronous 256K x 8 static memory module.
// Assumes the memory pins are wired directly and its outputs settle within one access time.
`timescale 1ns/1ps
`include "sram_host_params.svh"

module sram_host_ctrl #(
    parameter int AW = 18,
    parameter int DW = 8
) (
    input  wire logic          clk_sys,
    input  wire logic          srst,
    input  wire logic          req_valid,
    output logic               req_ready,
    input  wire logic          req_write,
    input  wire logic [AW-1:0] req_addr,
    input  wire logic [DW-1:0] req_wdata,
    input  wire logic [1:0]    req_nibble,
    output logic [DW-1:0]      rsp_rdata,
    output logic               rsp_valid,
    output logic [1:0]         density,
    output logic [AW-1:0]      mem_addr,
    output logic [DW-1:0]      write_data_in,
    output logic [1:0]         mem_sel_n,
    output logic               mem_we_n,
    input  wire logic [DW-1:0] mem_data_out,
    input  wire logic [1:0]    density_id_pins
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    sram_host_pkg::regs_t r;
    sram_host_pkg::regs_t next_r;

    // Nibble enable mask: a deselected half returns zero, since its outputs float.
    function automatic logic [DW-1:0] nib_mask(input logic [1:0] sel_n);
        nib_mask = {{(DW/2){~sel_n[1]}}, {(DW/2){~sel_n[0]}}};
    endfunction : nib_mask

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_r         = r;
        next_r.rvalid  = 1'b0;
        next_r.density = density_id_pins;
        case (r.state)
            sram_host_pkg::ST_IDLE: begin
                next_r.sel_n = `SEL_IDLE;
                next_r.we_n  = 1'b1;
                if (req_valid) begin
                    // Address and data go out with the select edge, so setup to start is met.
                    next_r.addr  = req_addr;
                    next_r.wdata = req_wdata;
                    next_r.sel_n = ~req_nibble;
                    next_r.cnt   = `CNT_ZERO;
                    if (req_write) begin
                        next_r.we_n  = 1'b0;
                        next_r.state = sram_host_pkg::ST_WRITE;
                    end else begin
                        next_r.state = sram_host_pkg::ST_READ;
                    end
                end
            end
            sram_host_pkg::ST_READ: begin
                // Whole read cycle is held for the rounded-up access time.
                next_r.cnt = r.cnt + 4'h1;
                if (r.cnt == 4'(`ACCESS_CYCLES - 1)) begin
                    // Sampled before the address moves, well inside the output hold window.
                    next_r.rdata  = mem_data_out & nib_mask(r.sel_n);
                    next_r.rvalid = 1'b1;
                    next_r.sel_n  = `SEL_IDLE;
                    next_r.state  = sram_host_pkg::ST_IDLE;
                end
            end
            sram_host_pkg::ST_WRITE: begin
                // Overlap of select and write enable lasts the setup counts.
                next_r.cnt = r.cnt + 4'h1;
                if (r.cnt == 4'(`WRITE_CYCLES - 1)) begin
                    // Both rise together, which keeps the outputs floating.
                    next_r.we_n  = 1'b1;
                    next_r.sel_n = `SEL_IDLE;
                    next_r.cnt   = `CNT_ZERO;
                    next_r.state = sram_host_pkg::ST_HOLD;
                end
            end
            sram_host_pkg::ST_HOLD: begin
                // Address and data stay put after the write ends.
                next_r.cnt = r.cnt + 4'h1;
                if (r.cnt == 4'(`HOLD_CYCLES - 1)) begin
                    next_r.state = sram_host_pkg::ST_IDLE;
                end
            end
            default: begin
                next_r.state = sram_host_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            r.state   <= sram_host_pkg::ST_IDLE;
            r.cnt     <= `CNT_ZERO;
            // A write cut by reset still ends on a strobe edge, so address and data stay put for it.
            // The overlap is cut short then, so the location being written is left undefined.
            r.addr    <= r.we_n ? '0 : r.addr;
            r.wdata   <= r.we_n ? `DATA_ZERO : r.wdata;
            r.sel_n   <= `SEL_IDLE;
            r.we_n    <= 1'b1;
            r.rdata   <= `DATA_ZERO;
            r.rvalid  <= 1'b0;
            r.density <= 2'h0;
        end else begin
            r <= next_r;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign req_ready     = (r.state == sram_host_pkg::ST_IDLE);
    assign rsp_rdata     = r.rdata;
    assign rsp_valid     = r.rvalid;
    assign density       = r.density;
    assign mem_addr      = r.addr;
    assign write_data_in = r.wdata;
    assign mem_sel_n     = r.sel_n;
    assign mem_we_n      = r.we_n;

endmodule : sram_host_ctrl

// ---- hdl/sram_host_params.svh ----
// Timing and layout constants for the host controller of the 256K x 8 static memory module.
// Assumes a 100 MHz system clock; every count is derived from a time in nanoseconds.
`ifndef SRAM_HOST_PARAMS_SVH
`define SRAM_HOST_PARAMS_SVH

`define CLK_PERIOD_NS            10
`define READ_CYCLE_MIN_NS        20
`define ADDRESS_ACCESS_MAX_NS    20
`define OUTPUT_HOLD_AFTER_ADDR_NS 3
`define ADDR_SETUP_TO_WRITE_END_NS 15
`define ADDR_HOLD_AFTER_WRITE_NS 2
`define ADDR_SETUP_TO_WRITE_START_NS 0
`define DATA_SETUP_TO_WRITE_END_NS 13
`define DATA_HOLD_AFTER_WRITE_NS 0

`define NS_TO_CYC(ns) ((((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS) < 1 ? 1 : \
                       (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS))

`define READ_CYCLES   `NS_TO_CYC(`READ_CYCLE_MIN_NS)
`define ACCESS_CYCLES `NS_TO_CYC(`ADDRESS_ACCESS_MAX_NS)
`define WRITE_CYCLES  `NS_TO_CYC(`ADDR_SETUP_TO_WRITE_END_NS)
`define HOLD_CYCLES   `NS_TO_CYC(`ADDR_HOLD_AFTER_WRITE_NS)

`define SEL_IDLE      2'h3
`define CNT_ZERO      4'h0
`define DATA_ZERO     8'h00

`endif

// ---- hdl/sram_host_pkg.sv ----
// Types for the host controller of the static memory module.
// Field widths are fixed here to match AW = 18 and DW = 8; nothing is taken from the params header.
package sram_host_pkg;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_READ,
        ST_WRITE,
        ST_HOLD
    } state_t;

    typedef struct packed {
        state_t      state;
        logic [3:0]  cnt;
        logic [17:0] addr;
        logic [7:0]  wdata;
        logic [1:0]  sel_n;
        logic        we_n;
        logic [7:0]  rdata;
        logic        rvalid;
        logic [1:0]  density;
    } regs_t;
endpackage : sram_host_pkg

// ---- verif/sram_host_checker.sv ----
// Concurrent checks on the memory host controller ports.
// Assumes it is bound into sram_host_ctrl and sees only its ports.
`timescale 1ns/1ps
module sram_host_checker #(parameter int AW = 18, parameter int DW = 8) (
    input wire logic          clk_sys, srst, req_valid, req_ready, req_write, rsp_valid, mem_we_n,
    input wire logic [1:0]    mem_sel_n,
    input wire logic [AW-1:0] mem_addr,
    input wire logic [DW-1:0] write_data_in
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);
    sequence rd_take; req_valid && req_ready && !req_write; endsequence
    sequence wr_take; req_valid && req_ready && req_write; endsequence
    read_cycle_a: assert property (rd_take |=> (mem_we_n && !req_ready)[*2]
        ##1 (rsp_valid && mem_sel_n == 2'h3)) else $error("bad read cycle");
    write_cycle_a: assert property (wr_take |=> (!mem_we_n && !req_ready)[*2]
        ##1 (mem_we_n && mem_sel_n == 2'h3) ##1 req_ready) else $error("bad write cycle");
    write_addr_a: assert property ($rose(mem_we_n) |->
        mem_addr == $past(mem_addr, 2) ##1 $stable(mem_addr)) else $error("write address moved");
    write_data_a: assert property ($rose(mem_we_n) |->
        write_data_in == $past(write_data_in, 2)) else $error("write data moved");
    we_busy_a: assert property (!mem_we_n |-> !req_ready) else $error("write strobe when idle");
    sel_addr_a: assert property (mem_sel_n != 2'h3 && $past(mem_sel_n) != 2'h3 |-> $stable(mem_addr))
        else $error("address moved while selected");
    rsp_pulse_a: assert property (rsp_valid |=> !rsp_valid) else $error("answer too long");
    idle_sel_a: assert property (req_ready |-> mem_sel_n == 2'h3 && mem_we_n)
        else $error("select when idle");
endmodule : sram_host_checker
bind sram_host_ctrl sram_host_checker #(.AW(AW), .DW(DW)) chk (.*);

// ---- verif/sram_model.sv ----
// Behavioural model of the 256K x 8 static memory module.
// Assumes zero-delay host pins; access time is not modelled.
`timescale 1ns/1ps
module sram_model #(parameter logic [1:0] DENSITY_CODE = 2'h2) (
    input wire logic [1:0]  mem_sel_n,
    input wire logic        mem_we_n,
    input wire logic [17:0] mem_addr,
    input wire logic [7:0]  write_data_in,
    output logic [7:0]      mem_data_out,
    output logic [1:0]      density_id_pins
);
    logic [7:0] m [0:262143];
    logic [7:0] q;
    logic [1:0] wr_on;
    logic [1:0] rd_on;
    assign q = m[mem_addr];
    assign density_id_pins = DENSITY_CODE;
    assign wr_on = ~mem_sel_n & {2{~mem_we_n}};
    assign rd_on = ~mem_sel_n & {2{mem_we_n}};
    // A nibble is stored as the overlap ends, so the data and address seen are those at the ending edge.
    for (genvar i = 0; i < 2; i++) begin : g
        always @(negedge wr_on[i]) m[mem_addr][i*4+:4] = write_data_in[i*4+:4];
    end
    // Released nibbles show the inverse, so a stale value never passes as read data.
    assign mem_data_out = q ^ ~{{4{rd_on[1]}}, {4{rd_on[0]}}};
endmodule : sram_model

// ---- verif/test_async_sram_256kx8_port.sv ----
// Self-checking bench for the memory host controller.
// Assumes sram_model on the memory pins and the bound checker.
`timescale 1ns/1ps
module test_async_sram_256kx8_port;
    typedef struct packed {logic w; logic [17:0] a; logic [7:0] d; logic [1:0] n; logic [7:0] e;} row_t;
    logic        clk_sys = 0, srst = 1, req_valid = 0, req_write = 0;
    logic [17:0] req_addr = 0, mem_addr;
    logic [7:0]  req_wdata = 0, rsp_rdata, write_data_in, mem_data_out;
    logic [1:0]  req_nibble = 0, density, mem_sel_n, density_id_pins;
    logic        req_ready, rsp_valid, mem_we_n;
    int          mismatches = 0, total_checks = 0;
    row_t rows [8] = '{'{1, 18'h3FFFF, 8'hA5, 2'h3, 8'h0}, '{0, 18'h3FFFF, 8'h0, 2'h3, 8'hA5},
        '{0, 18'h3FFFF, 8'h0, 2'h1, 8'h05}, '{0, 18'h3FFFF, 8'h0, 2'h2, 8'hA0},
        '{1, 18'h0, 8'h3C, 2'h3, 8'h0}, '{1, 18'h0, 8'hF0, 2'h1, 8'h0},
        '{0, 18'h0, 8'h0, 2'h3, 8'h30}, '{0, 18'h3FFFF, 8'h0, 2'h0, 8'h0}};
    always #5 clk_sys = ~clk_sys;
    sram_host_ctrl dut (.*);
    sram_model mem (.*);
    task chk(input string n, input logic [17:0] s, e);
        total_checks++;
        if (s !== e) begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task op(input row_t r);
        int k;
        @(posedge clk_sys); #1;
        {req_write, req_addr, req_wdata, req_nibble, req_valid} = {r.w, r.a, r.d, r.n, 1'b1};
        k = 0;
        while (req_ready !== 1'b1 && k < 9) begin @(posedge clk_sys); #1; k++; end
        @(posedge clk_sys); #1;
        req_valid = 0;
        k = 0;
        while (!r.w && rsp_valid !== 1'b1 && k < 9) begin @(posedge clk_sys); #1; k++; end
        if (!r.w) chk("latency", 18'(k), 18'h2);
        if (!r.w) chk("rdata", rsp_rdata, r.e);
    endtask : op
    task results;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : results
    initial begin
        repeat (20) @(posedge clk_sys);
        #1 srst = 0;
        chk("sel", mem_sel_n, 2'h3);
        foreach (rows[i]) op(rows[i]);
        chk("density", density, 2'h2);
        // A reset in mid-write must drop both strobes at once.
        @(posedge clk_sys); #1;
        {req_write, req_valid, req_nibble} = 4'hF;
        @(posedge clk_sys); #1;
        {req_valid, srst} = 2'h1;
        chk("we", mem_we_n, 1'b0);
        @(posedge clk_sys); #1;
        srst = 0;
        chk("we", mem_we_n, 1'b1);
        chk("sel", mem_sel_n, 2'h3);
        for (int i = 4; i < 7; i++) op(rows[i]);
        results();
    end
    initial begin
        #20000;
        mismatches++;
        results();
    end
endmodule : test_async_sram_256kx8_port
